/* File: bram_master_model.sv */
// Behavioural model of the four bus masters sharing the granted slot.
// Assumes the bench hands it at most one request per cycle on cmd.
module bram_master_model
  import bram_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command from the bench
  input wire bram_req_type cmd,
  // Granted access and its answer
  output bram_req_type acc_req,
  input wire bram_resp_type acc_resp,
  // Abort taken by the master that issued the access
  output logic own_abort
);
  // ==========================================================
  // Request slot
  bram_req_type next_req; // Idle slot scrambles stale fields
  logic [1:0] last_master; // Issuer of the access in flight
  // Stale fields are inverted so nothing can lean on old values
  assign next_req = cmd.valid ? cmd : {1'b0, ~acc_req[37:0]};
  // Abort is broadcast; only its issuer acts on it
  assign own_abort = acc_resp.abort && (acc_resp.master == last_master);
  // One request per edge, never held over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_req <= '0;
      last_master <= 2'h0;
    end else begin
      acc_req <= next_req;
      if (cmd.valid) begin
        last_master <= cmd.master;
      end
    end
  end
endmodule : bram_master_model

/* File: bram_monitor.sv */
// Page-zero mapping, boot select, remap, alignment check and abort status.
// Assumes an arbiter ahead of it presents one granted access per cycle,
// and that all interrupt inputs come from logic on pclk.
// Operation
// - Boot pin sampled in last two reset cycles
// - Page zero shows ROM or chip select zero
// - Remapped page zero shows internal SRAM
// - Aliased memory stays at native address too
// - External area zero decoded at native base
// - Lowest 32 bytes of page zero are vectors
// - Boot pin freed for general I/O after reset
// - Writing one toggles the remap state
// - Abort only on undefined or misaligned access
// - Abort broadcast; only issuing master acts
// - Full 32-bit faulting address is captured
// - Size and access type recorded on abort
// - Separate flags for undefined and misaligned
// - One source bit per master, last abort
// - Sticky per-master bit until status read
// - Data abort stores the data address
// - Misaligned word access aborted and cancelled
// - Odd half-word access aborted and cancelled
// - Processor instruction fetches skip alignment check
// - No own interrupt; bus interrupt passes through
// - Pass-through ORed into system interrupt source one
// - Internal area at 0x0040_0000 up is undefined
// - Masters numbered processor, DMA, USB, MAC
module bram_monitor
  import bram_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot strap pin
  input wire logic boot_select_pin,
  output logic boot_pin_released,
  // Granted access and its decode
  input wire bram_req_type acc_req,
  output bram_resp_type acc_resp,
  // Interrupt lines
  input wire logic ebi_irq,
  input wire logic rtc_irq,
  input wire logic system_timer_irq,
  input wire logic debug_unit_irq,
  input wire logic power_mgmt_irq,
  output logic sys_irq_src1
);
  // ==========================================================
  // Boot strap capture
  logic boot_sync1; // First synchroniser stage
  logic boot_sync2; // Second synchroniser stage
  logic boot_prev; // Sample one cycle older than boot_sync2
  logic boot_rom; // Latched choice: 1 boots from internal ROM
  logic boot_done; // High once the strap has been captured

  // Strap chain runs without reset so it keeps sampling while held
  always_ff @(posedge pclk) begin
    boot_sync1 <= boot_select_pin;
    boot_sync2 <= boot_sync1;
    boot_prev <= boot_sync2;
  end

  // Catch the last two in-reset samples at the first edge after release
  // Both samples high are needed, so a glitch never selects the ROM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done <= 1'b0;
      boot_rom <= 1'b0;
    end else if (!boot_done) begin
      boot_done <= 1'b1;
      boot_rom <= boot_sync2 & boot_prev;
    end
  end

  // Pin handed to the I/O mux once the strap is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_pin_released <= 1'b0;
    end else begin
      boot_pin_released <= boot_done;
    end
  end

  // ==========================================================
  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire hit_remap = (paddr == BRAM_OFF_REMAP);
  wire hit_status = (paddr == BRAM_OFF_STATUS);
  wire hit_addr = (paddr == BRAM_OFF_ADDR);
  wire hit_any = hit_remap | hit_status | hit_addr;
  wire toggle_wr = apb_access & pwrite & hit_remap & pstrb[0] &
                   pwdata[BRAM_REMAP_BIT];
  wire status_rd = apb_access & ~pwrite & hit_status;

  logic remapped; // Remap state, off after reset

  // Each write of one flips the mapping; zero has no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remapped <= 1'b0;
    end else if (toggle_wr) begin
      remapped <= ~remapped;
    end
  end

  // ==========================================================
  // Address decode and alignment check
  wire [3:0] area = acc_req.addr[31:28];
  wire [7:0] int_sel = acc_req.addr[27:20];
  wire in_int = (area == BRAM_AREA_INT);
  wire in_ext = (area >= BRAM_AREA_EXT_LO) && (area <= BRAM_AREA_EXT_HI);
  wire in_per = (area == BRAM_AREA_PERIPH);
  wire int_ok = in_int && (int_sel <= BRAM_INT_USB);
  wire undef_hit = ~(int_ok | in_ext | in_per);
  wire is_fetch = (acc_req.master == BRAM_MST_CPU) &&
                  (acc_req.kind == BRAM_KIND_FETCH);
  wire mis_word = (acc_req.size == BRAM_SZ_WORD) &&
                  (acc_req.addr[1:0] != 2'h0);
  wire mis_half = (acc_req.size == BRAM_SZ_HALF) && acc_req.addr[0];
  wire misal_hit = ~is_fetch & (mis_word | mis_half);
  wire abort_now = acc_req.valid & (undef_hit | misal_hit);

  // Area 0 target: SRAM when remapped, else the strap's choice
  // Vectors sit in its first 32 bytes, so this also picks them
  wire page0_is_ext = ~remapped & ~boot_rom;
  wire [31:0] page0_base = remapped ? BRAM_SRAM_BASE : BRAM_EXT0_BASE;

  bram_target_type next_target; // Combinational decode of the target
  logic [2:0] next_cs; // External chip select index
  logic [31:0] next_addr; // Address as seen by the target

  // Native addresses always decode, so aliased memory stays reachable
  always_comb begin
    next_target = BRAM_TGT_NONE;
    next_cs = 3'h0;
    next_addr = acc_req.addr;
    if (in_ext) begin
      next_target = BRAM_TGT_EXT;
      next_cs = 3'(area - BRAM_AREA_EXT_LO);
    end else if (in_per) begin
      next_target = BRAM_TGT_PERIPH;
    end else if (int_ok && int_sel == BRAM_INT_ROM) begin
      next_target = BRAM_TGT_ROM;
    end else if (int_ok && int_sel == BRAM_INT_SRAM) begin
      next_target = BRAM_TGT_SRAM;
    end else if (int_ok && int_sel == BRAM_INT_USB) begin
      next_target = BRAM_TGT_USB;
    end else if (int_ok && page0_is_ext) begin
      next_target = BRAM_TGT_EXT;
      next_addr = page0_base | {12'h000, acc_req.addr[19:0]};
    end else if (int_ok && remapped) begin
      next_target = BRAM_TGT_SRAM;
      next_addr = page0_base | {12'h000, acc_req.addr[19:0]};
    end else if (int_ok) begin
      next_target = BRAM_TGT_ROM;
    end
  end

  // Answer registered one cycle after the request; aborts cancel it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_resp <= '0;
    end else begin
      acc_resp.valid <= acc_req.valid & ~abort_now;
      acc_resp.target <= abort_now ? BRAM_TGT_NONE : next_target;
      acc_resp.ext_cs <= next_cs;
      acc_resp.addr <= next_addr;
      acc_resp.abort <= abort_now;
      acc_resp.master <= acc_req.master;
    end
  end

  // ==========================================================
  // Abort status
  logic undef_flag; // Last abort hit an undefined address
  logic misal_flag; // Last abort was misaligned
  logic [1:0] abort_size; // Size of the last aborted access
  logic [1:0] abort_kind; // Type of the last aborted access
  logic [3:0] src_flags; // Source of the last abort, one-hot
  logic [3:0] sticky_flags; // Earlier aborts not shown in src_flags
  logic [3:0] seen_flags; // Master aborted since the last status read
  logic [31:0] abort_addr; // Faulting address, captured whole
  wire [3:0] new_src = 4'(1) << acc_req.master;

  // Cause, size, type, source and address of the newest abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      undef_flag <= 1'b0;
      misal_flag <= 1'b0;
      abort_size <= 2'h0;
      abort_kind <= 2'h0;
      src_flags <= 4'h0;
      abort_addr <= BRAM_ADDR_RESET;
    end else if (abort_now) begin
      undef_flag <= undef_hit;
      misal_flag <= misal_hit;
      abort_size <= acc_req.size;
      abort_kind <= acc_req.kind;
      src_flags <= new_src;
      abort_addr <= acc_req.addr;
    end
  end

  // A displaced abort moves into the sticky bits; set wins over read clear
  // Only aborts since the last read count, so an already-read abort
  // that is later displaced never raises a stale sticky bit
  generate
    for (genvar m = 0; m < BRAM_MASTERS; m++) begin : g_sticky
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          seen_flags[m] <= 1'b0;
        end else if (abort_now && new_src[m]) begin
          seen_flags[m] <= 1'b1;
        end else if (status_rd) begin
          seen_flags[m] <= 1'b0;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sticky_flags[m] <= 1'b0;
        end else if (abort_now && src_flags[m] && seen_flags[m]) begin
          sticky_flags[m] <= 1'b1;
        end else if (status_rd) begin
          sticky_flags[m] <= 1'b0;
        end
      end
    end
  endgenerate

  // Status word assembled from the fields
  logic [31:0] status_word;
  always_comb begin
    status_word = BRAM_STATUS_RESET;
    status_word[BRAM_ST_UNDEF] = undef_flag;
    status_word[BRAM_ST_MISAL] = misal_flag;
    status_word[BRAM_ST_SIZE +: 2] = abort_size;
    status_word[BRAM_ST_TYPE +: 2] = abort_kind;
    status_word[BRAM_ST_SRC +: 4] = src_flags;
    status_word[BRAM_ST_STICKY +: 4] = sticky_flags;
  end

  wire [31:0] read_mux = hit_status ? status_word :
                         hit_addr ? abort_addr : 32'h0000_0000;

  // Read data and error prepared in setup, so the access has no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : read_mux;
        pslverr <= ~hit_any;
      end
    end
  end

  // ==========================================================
  // Interrupt pass-through, registered only to keep outputs clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_irq_src1 <= 1'b0;
    end else begin
      sys_irq_src1 <= ebi_irq | rtc_irq | system_timer_irq |
                      debug_unit_irq | power_mgmt_irq;
    end
  end

  // ==========================================================
  // Checks
  wire req_word_mis = acc_req.valid && mis_word && !is_fetch;
  misalign_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    req_word_mis |=> acc_resp.abort && misal_flag && !acc_resp.valid)
    else $error("misaligned word not aborted");
  half_odd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_req.valid && mis_half && !is_fetch) |=> acc_resp.abort)
    else $error("odd half-word not aborted");
  fetch_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_req.valid && is_fetch && !undef_hit) |=> !acc_resp.abort)
    else $error("instruction fetch was aborted");
  undef_area_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_req.valid && in_int && int_sel > BRAM_INT_USB)
    |=> acc_resp.abort && undef_flag)
    else $error("undefined internal address not aborted");
  addr_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_resp.abort |-> abort_addr == $past(acc_req.addr))
    else $error("abort address not captured");
  src_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_resp.abort |-> src_flags == (4'(1) << acc_resp.master))
    else $error("abort source bit wrong");
  remap_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    toggle_wr |=> remapped != $past(remapped))
    else $error("remap did not toggle");
  page0_sram_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_req.valid && in_int && int_sel == BRAM_INT_PAGE0 && remapped
     && !misal_hit) |=> acc_resp.target == BRAM_TGT_SRAM)
    else $error("remapped page zero not on SRAM");
  sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (abort_now && src_flags[acc_req.master] && seen_flags[acc_req.master])
    |=>
    sticky_flags[$past(acc_req.master)])
    else $error("sticky bit not set");
  irq_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 sys_irq_src1 == $past(ebi_irq | rtc_irq | system_timer_irq |
    debug_unit_irq | power_mgmt_irq))
    else $error("system interrupt not passed");
  cov_remap_c: cover property (@(posedge pclk) disable iff (!presetn)
    toggle_wr ##[1:20] toggle_wr);
  cov_abort_c: cover property (@(posedge pclk) disable iff (!presetn)
    abort_now ##1 status_rd);
  cov_sticky_c: cover property (@(posedge pclk) disable iff (!presetn)
    abort_now && src_flags[acc_req.master]);
endmodule : bram_monitor

/* File: bram_monitor_test.sv */
// Self-checking bench for the boot remap and abort monitor.
// Assumes one 25 MHz clock; registers reached over APB.
module bram_monitor_test
  import bram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observation
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic boot_pin = 1'b0;
  logic [4:0] irq_in = 5'h00; // ebi, rtc, timer, debug, power
  bram_req_type cmd = '0;
  bram_req_type acc_req;
  bram_resp_type acc_resp;
  logic [31:0] prdata;
  logic pready, pslverr, pin_free, sys_irq, own_abort;
  logic [31:0] rd; // Read data taken at the access edge
  logic err; // Error flag taken at the access edge
  int num_errors = 0;
  int n_checks = 0;
  always #20 pclk = ~pclk;
  // ==========================================================
  // Design and far side
  bram_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_select_pin(boot_pin), .boot_pin_released(pin_free),
    .acc_req(acc_req), .acc_resp(acc_resp), .ebi_irq(irq_in[0]),
    .rtc_irq(irq_in[1]), .system_timer_irq(irq_in[2]),
    .debug_unit_irq(irq_in[3]), .power_mgmt_irq(irq_in[4]),
    .sys_irq_src1(sys_irq));
  bram_master_model masters (.pclk(pclk), .presetn(presetn), .cmd(cmd),
    .acc_req(acc_req), .acc_resp(acc_resp), .own_abort(own_abort));
  // ==========================================================
  // Shared tasks
  task automatic stop_test;
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Pin level flips away from the wanted one early, so only the
  // last cycles of reset can pick the boot memory
  task automatic rst(input logic pin);
    @(posedge pclk);
    presetn <= 1'b0;
    boot_pin <= ~pin;
    repeat (2) @(posedge pclk);
    boot_pin <= pin;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    boot_pin <= ~pin; // Pin now general I/O
  endtask : rst
  // One APB transfer; waits on pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One granted access; answer is looked at in its one cycle
  task automatic acc(input logic [1:0] m, input logic [31:0] a,
                     input logic [1:0] s, input logic [1:0] k);
    @(posedge pclk);
    cmd <= {1'b1, m, a, s, k};
    @(posedge pclk);
    cmd <= '0;
    @(posedge pclk);
    #1;
  endtask : acc
  // Word read by the processor, then target, chip select, address
  task automatic look(input logic [31:0] a, input bram_target_type t,
                      input logic [31:0] ta);
    logic [2:0] cs;
    acc(BRAM_MST_CPU, a, BRAM_SZ_WORD, BRAM_KIND_READ);
    cs = (t == BRAM_TGT_EXT) ? acc_resp.ext_cs : 3'h0;
    chk({23'h0, acc_resp.valid, acc_resp.abort, cs, acc_resp.target},
        {23'h0, 1'b1, 1'b0, 3'h0, t});
    chk(acc_resp.addr, ta);
  endtask : look
  function automatic logic [31:0] st(input logic [1:0] m, s, k,
                                     input logic u, mi,
                                     input logic [3:0] sv);
    st = 32'h0000_0000;
    st[BRAM_ST_UNDEF] = u;
    st[BRAM_ST_MISAL] = mi;
    st[BRAM_ST_SIZE +: 2] = s;
    st[BRAM_ST_TYPE +: 2] = k;
    st[BRAM_ST_SRC + m] = 1'b1;
    st[BRAM_ST_STICKY +: 4] = sv;
  endfunction : st
  // Aborted access: answer, status and captured address
  task automatic abt(input logic [1:0] m, input logic [31:0] a,
                     input logic [1:0] s, k, input logic u, mi);
    acc(m, a, s, k);
    chk({27'h0, acc_resp.abort, acc_resp.valid, own_abort, acc_resp.master},
        {27'h0, 1'b1, 1'b0, 1'b1, m});
    apb(1'b0, BRAM_OFF_STATUS, 32'h0);
    chk(rd, st(m, s, k, u, mi, 4'h0));
    apb(1'b0, BRAM_OFF_ADDR, 32'h0);
    chk(rd, a);
  endtask : abt
  // ==========================================================
  // Scenarios
  task automatic t_boot_ext;
    #1;
    chk({31'h0, pin_free}, 32'h1);
    look(32'h0000_0004, BRAM_TGT_EXT, 32'h1000_0004);
    look(32'h1000_0008, BRAM_TGT_EXT, 32'h1000_0008);
  endtask : t_boot_ext
  task automatic t_remap;
    apb(1'b1, BRAM_OFF_REMAP, 32'h1);
    look(32'h0000_001C, BRAM_TGT_SRAM, 32'h0020_001C);
    look(32'h0020_0010, BRAM_TGT_SRAM, 32'h0020_0010);
    apb(1'b1, BRAM_OFF_REMAP, 32'h0);
    look(32'h0000_0000, BRAM_TGT_SRAM, 32'h0020_0000);
    apb(1'b1, BRAM_OFF_REMAP, 32'h1);
    look(32'h0000_0004, BRAM_TGT_EXT, 32'h1000_0004);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, BRAM_OFF_REMAP, 32'h1); // Left on; the next reset turns it off again
  endtask : t_remap
  task automatic t_boot_rom;
    apb(1'b0, BRAM_OFF_STATUS, 32'h0);
    chk(rd, BRAM_STATUS_RESET);
    look(32'h0000_0004, BRAM_TGT_ROM, 32'h0000_0004);
    look(32'h0010_0004, BRAM_TGT_ROM, 32'h0010_0004);
  endtask : t_boot_rom
  task automatic t_aborts;
    abt(2'h0, 32'h0000_0002, BRAM_SZ_WORD, BRAM_KIND_READ, 0, 1);
    abt(2'h3, 32'h0020_0003, BRAM_SZ_WORD, BRAM_KIND_WRITE, 0, 1);
    abt(2'h1, 32'h0020_0001, BRAM_SZ_HALF, BRAM_KIND_WRITE, 0, 1);
    abt(2'h2, 32'h0040_0000, BRAM_SZ_WORD, BRAM_KIND_READ, 1, 0);
    abt(2'h3, 32'h9000_0001, BRAM_SZ_HALF, BRAM_KIND_READ, 1, 1);
    abt(2'h1, 32'hA000_0000, BRAM_SZ_BYTE, BRAM_KIND_FETCH, 1, 0);
    acc(2'h0, 32'h0010_0002, BRAM_SZ_WORD, BRAM_KIND_FETCH);
    chk({30'h0, acc_resp.abort, acc_resp.valid}, 32'h1);
  endtask : t_aborts
  // Second abort hides the first issuer in its saved bit
  task automatic t_sticky;
    acc(2'h0, 32'h0000_0001, BRAM_SZ_HALF, BRAM_KIND_READ);
    acc(2'h1, 32'hB000_0000, BRAM_SZ_WORD, BRAM_KIND_WRITE);
    apb(1'b0, BRAM_OFF_STATUS, 32'h0);
    chk(rd, st(2'h1, BRAM_SZ_WORD, BRAM_KIND_WRITE, 1, 0, 4'h1));
    apb(1'b0, BRAM_OFF_STATUS, 32'h0);
    chk(rd, st(2'h1, BRAM_SZ_WORD, BRAM_KIND_WRITE, 1, 0, 4'h0));
  endtask : t_sticky
  task automatic t_irq;
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      irq_in <= 5'h01 << i;
      repeat (2) @(posedge pclk);
      #1;
      chk({31'h0, sys_irq}, 32'h1);
    end
    @(posedge pclk);
    irq_in <= 5'h00;
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, sys_irq}, 32'h0);
  endtask : t_irq
  // ==========================================================
  // Main sequence and hang guard
  initial begin
    rst(1'b0);
    t_boot_ext;
    t_remap;
    rst(1'b1);
    t_boot_rom;
    t_aborts;
    t_sticky;
    t_irq;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    stop_test;
  end
endmodule : bram_monitor_test

/* File: bram_pkg.sv */
// Shared constants and types for the boot remap and abort monitor.
// Assumes one system clock domain and a 32-bit APB register port.
package bram_pkg;
  // ==========================================================
  // Register offsets (byte addresses on the APB port)
  localparam logic [7:0] BRAM_OFF_REMAP = 8'h00;
  localparam logic [7:0] BRAM_OFF_STATUS = 8'h04;
  localparam logic [7:0] BRAM_OFF_ADDR = 8'h08;
  // ==========================================================
  // Status field positions
  localparam int BRAM_ST_UNDEF = 0;
  localparam int BRAM_ST_MISAL = 1;
  localparam int BRAM_ST_SIZE = 8;
  localparam int BRAM_ST_TYPE = 10;
  localparam int BRAM_ST_SRC = 16;
  localparam int BRAM_ST_STICKY = 24;
  localparam int BRAM_REMAP_BIT = 0;
  localparam logic [31:0] BRAM_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] BRAM_ADDR_RESET = 32'h0000_0000;
  // ==========================================================
  // Address map
  localparam logic [3:0] BRAM_AREA_INT = 4'h0;
  localparam logic [3:0] BRAM_AREA_EXT_LO = 4'h1;
  localparam logic [3:0] BRAM_AREA_EXT_HI = 4'h8;
  localparam logic [3:0] BRAM_AREA_PERIPH = 4'hF;
  localparam logic [7:0] BRAM_INT_PAGE0 = 8'h00;
  localparam logic [7:0] BRAM_INT_ROM = 8'h01;
  localparam logic [7:0] BRAM_INT_SRAM = 8'h02;
  localparam logic [7:0] BRAM_INT_USB = 8'h03;
  localparam logic [31:0] BRAM_SRAM_BASE = 32'h0020_0000;
  localparam logic [31:0] BRAM_EXT0_BASE = 32'h1000_0000;
  localparam logic [31:0] BRAM_VECTOR_TOP = 32'h0000_0020;
  localparam int BRAM_MASTERS = 4;
  localparam logic [1:0] BRAM_MST_CPU = 2'h0;
  // ==========================================================
  // Access size and kind encodings
  localparam logic [1:0] BRAM_SZ_BYTE = 2'h0;
  localparam logic [1:0] BRAM_SZ_HALF = 2'h1;
  localparam logic [1:0] BRAM_SZ_WORD = 2'h2;
  localparam logic [1:0] BRAM_KIND_READ = 2'h0;
  localparam logic [1:0] BRAM_KIND_WRITE = 2'h1;
  localparam logic [1:0] BRAM_KIND_FETCH = 2'h2;
  // ==========================================================
  // Decoded target of one access
  typedef enum logic [3:0] {
    BRAM_TGT_NONE, BRAM_TGT_ROM, BRAM_TGT_SRAM, BRAM_TGT_USB,
    BRAM_TGT_EXT, BRAM_TGT_PERIPH
  } bram_target_type;
  // One granted access from the arbiter
  typedef struct packed {
    logic valid;
    logic [1:0] master;
    logic [31:0] addr;
    logic [1:0] size;
    logic [1:0] kind;
  } bram_req_type;
  // Registered decode answer for that access
  typedef struct packed {
    logic valid;
    bram_target_type target;
    logic [2:0] ext_cs;
    logic [31:0] addr;
    logic abort;
    logic [1:0] master;
  } bram_resp_type;
endpackage : bram_pkg
